// File: hdl/gorc_cfg.svh
// Constants for the global oscillator, reset and power-down controller
`ifndef GORC_CFG_SVH
`define GORC_CFG_SVH
`define GORC_OSC_HZ 8000000
`define GORC_TAP0 4
`define GORC_TAP1 9
`define GORC_TAP2 14
`define GORC_TAP3 19
`define GORC_DIV_W 20
`define GORC_POR_CYCLES 64
`define GORC_CLR_CYCLES 32
`define GORC_CFGCLK_HALF 4
`endif

// File: hdl/gorc_pkg.sv
// Types for the global oscillator, reset and power-down controller
package gorc_pkg;
    typedef enum logic [2:0] {
        ST_POR, ST_CLEAR, ST_CONFIG, ST_USER, ST_PDOWN
    } gorc_state_type;
endpackage : gorc_pkg

// File: hdl/gorc_osc_if.sv
// Oscillator signals passed between the controller and the divider
interface gorc_osc_if;
    logic run;
    logic [3:0] taps;
    modport ctrl (output run, input taps);
    modport div (input run, output taps);
endinterface : gorc_osc_if

// File: hdl/gorc_divider.sv
// Oscillator divider with resynchronized taps
`include "gorc_cfg.svh"
module gorc_divider #(
    parameter int DIV_W = `GORC_DIV_W
) (
    input wire logic i_clk,     // Oscillator clock
    input wire logic i_sys_rst, // Sync reset
    gorc_osc_if.div osc         // Run request and taps
);
    localparam int TAP_POS [4] = '{`GORC_TAP0, `GORC_TAP1, `GORC_TAP2, `GORC_TAP3};
    initial begin
        if (DIV_W <= `GORC_TAP3) $error("divider too narrow for highest tap");
    end
    logic [DIV_W-1:0] cnt_q;
    // Counter clears to zero while the oscillator is stopped
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !osc.run) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    // Retime each tap so user logic sees glitch-free edges
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_tap
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    osc.taps[g] <= 1'b0;
                end else begin
                    osc.taps[g] <= cnt_q[TAP_POS[g]];
                end
            end
        end
    endgenerate
endmodule : gorc_divider

// File: hdl/gorc_top.sv
// Global oscillator, set/reset, three-state and power-down controller
`include "gorc_cfg.svh"
module gorc_top #(
    parameter int NFF = 8,  // Number of user storage bits served
    parameter int NIN = 8,  // Number of user inputs
    parameter int NOUT = 8  // Number of user outputs
) (
    input wire logic i_clk,                // Oscillator clock, 8 MHz nominal
    input wire logic i_sys_rst,            // Power-on reset, active high
    input wire logic i_power_down_pin_n,   // Low requests power-down
    input wire logic i_reconfig,           // Restart configuration pulse
    input wire logic i_master_mode,        // Master configuration mode
    input wire logic i_cfg_done,           // Configuration loading finished
    input wire logic i_osc_used,           // Oscillator primitive instantiated
    input wire logic [1:0] i_sel_a,        // First tap select
    input wire logic [1:0] i_sel_b,        // Second tap select
    input wire logic i_grst_pin,           // Reset pin source
    input wire logic i_grst_node,          // Reset internal source
    input wire logic i_grst_use_node,      // Select internal source
    input wire logic i_grst_invert,        // Invert reset sense
    input wire logic i_gtri_pin,           // Three-state pin source
    input wire logic i_gtri_node,          // Three-state internal source
    input wire logic i_gtri_use_node,      // Select internal source
    input wire logic i_gtri_invert,        // Invert three-state sense
    input wire logic i_extest,             // Boundary scan external test active
    input wire logic [NFF-1:0] i_ff_set,   // 1: storage bit set-type
    input wire logic [NFF-1:0] i_ff_d,     // Storage bit data
    input wire logic [NIN-1:0] i_user_in,  // User inputs
    input wire logic [NOUT-1:0] i_out_en,  // User output enables
    output logic [NFF-1:0] o_ff_q,         // Storage bit values
    output logic [NIN-1:0] o_in_gated,     // Inputs as seen by core
    output logic [NOUT-1:0] o_out_oe,      // Effective output enables
    output logic o_global_set_reset,       // Global reset active
    output logic o_osc_out,                // Oscillator enable seen by user
    output logic o_tap_a,                  // Selected tap A
    output logic o_tap_b,                  // Selected tap B
    output logic o_configuration_clock,    // Master mode config clock
    output logic o_cfg_active,             // Configuring
    output logic o_init_valid,             // Initialization status valid
    output logic o_user_mode,              // Device in user operation
    output logic o_power_down              // Power-down state
);
    initial begin
        if (NFF < 1 || NIN < 1 || NOUT < 1) $error("widths must be at least one");
    end

    gorc_pkg::gorc_state_type state_q;
    logic [6:0] cnt_q;
    logic [2:0] cfgclk_cnt_q;
    logic cfg_started_q;
    logic pd;
    logic grst_src;
    logic gtri_src;
    logic grst_act;
    gorc_osc_if osc ();

    gorc_divider u_div (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .osc(osc)
    );

    // Source selection with optional inversion
    function automatic logic pick_src(input logic pin, input logic node,
                                      input logic use_node, input logic inv);
        pick_src = (use_node ? node : pin) ^ inv;
    endfunction : pick_src

    function automatic logic tap_of(input logic [3:0] taps, input logic [1:0] sel);
        tap_of = taps[sel];
    endfunction : tap_of

    assign pd = !i_power_down_pin_n;
    assign grst_src = pick_src(i_grst_pin, i_grst_node, i_grst_use_node, i_grst_invert);
    assign gtri_src = pick_src(i_gtri_pin, i_gtri_node, i_gtri_use_node, i_gtri_invert);
    // Reset held at power-up, reconfiguration and on user request
    assign grst_act = (state_q != gorc_pkg::ST_USER) || grst_src;

    // Oscillator runs outside user mode, and in user mode only if used
    assign osc.run = (state_q != gorc_pkg::ST_USER) || i_osc_used;

    // Sequencer: timeout, memory clear, configuration, user, power-down
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= gorc_pkg::ST_POR;
            cnt_q <= 7'h00;
            cfg_started_q <= 1'b0;
        end else if (pd) begin
            state_q <= gorc_pkg::ST_PDOWN;
            cnt_q <= 7'h00;
        end else begin
            case (state_q)
                gorc_pkg::ST_POR: begin
                    cnt_q <= cnt_q + 7'h01;
                    if (cnt_q == 7'(`GORC_POR_CYCLES - 1)) begin
                        state_q <= gorc_pkg::ST_CLEAR;
                        cnt_q <= 7'h00;
                    end
                end
                gorc_pkg::ST_CLEAR: begin
                    cnt_q <= cnt_q + 7'h01;
                    if (cnt_q == 7'(`GORC_CLR_CYCLES - 1)) begin
                        state_q <= gorc_pkg::ST_CONFIG;
                        cfg_started_q <= 1'b1;
                    end
                end
                gorc_pkg::ST_CONFIG: begin
                    if (i_cfg_done) begin
                        state_q <= gorc_pkg::ST_USER;
                    end
                end
                gorc_pkg::ST_USER: begin
                    if (i_reconfig) begin
                        state_q <= gorc_pkg::ST_CLEAR;
                        // A stale done level must not let power-down skip the reload
                        cfg_started_q <= 1'b0;
                        cnt_q <= 7'h00;
                    end
                end
                gorc_pkg::ST_PDOWN: begin
                    // Leave only when the pin returned high; configuration kept if loaded
                    if (cfg_started_q && i_cfg_done) begin
                        state_q <= gorc_pkg::ST_USER;
                    end else begin
                        state_q <= gorc_pkg::ST_POR;
                        cfg_started_q <= 1'b0;
                    end
                end
                default: state_q <= gorc_pkg::ST_POR;
            endcase
        end
    end

    // Master configuration clock: divided oscillator, only while configuring
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || state_q != gorc_pkg::ST_CONFIG || !i_master_mode) begin
            cfgclk_cnt_q <= 3'h0;
            o_configuration_clock <= 1'b0;
        end else if (cfgclk_cnt_q == 3'(`GORC_CFGCLK_HALF - 1)) begin
            cfgclk_cnt_q <= 3'h0;
            o_configuration_clock <= !o_configuration_clock;
        end else begin
            cfgclk_cnt_q <= cfgclk_cnt_q + 3'h1;
        end
    end

    // User storage: global reset uses each bit's own set/reset polarity
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_ff_q <= '0;
        end else if (grst_act || pd) begin
            o_ff_q <= i_ff_set;
        end else begin
            o_ff_q <= i_ff_d;
        end
    end

    // Inputs read low in power-down; output drivers float under three-state unless external test is active
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_in_gated <= '0;
            o_out_oe <= '0;
        end else begin
            o_in_gated <= pd ? '0 : i_user_in;
            o_out_oe <= (gtri_src && !i_extest) ? '0 : i_out_en;
        end
    end

    // Status outputs
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_global_set_reset <= 1'b1;
            o_osc_out <= 1'b1;
            o_tap_a <= 1'b0;
            o_tap_b <= 1'b0;
            o_cfg_active <= 1'b0;
            o_init_valid <= 1'b0;
            o_user_mode <= 1'b0;
            o_power_down <= 1'b0;
        end else begin
            o_global_set_reset <= grst_act || pd;
            o_osc_out <= osc.run;
            o_tap_a <= tap_of(osc.taps, i_sel_a);
            o_tap_b <= tap_of(osc.taps, i_sel_b);
            o_cfg_active <= (state_q == gorc_pkg::ST_CONFIG) && !pd;
            // Status is meaningless while power-down interrupts configuration
            o_init_valid <= !pd && (state_q != gorc_pkg::ST_PDOWN);
            o_user_mode <= (state_q == gorc_pkg::ST_USER) && !pd;
            o_power_down <= pd;
        end
    end

    // Power-down request forces user storage to its set/reset values one cycle later
    a_pd_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        pd |=> (o_ff_q == $past(i_ff_set)) && o_power_down)
        else $error("power-down did not force storage");
    a_in_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        pd |=> o_in_gated == '0)
        else $error("inputs not low in power-down");
    // Three-state must reach every driver unless external test owns the pins
    a_gtri_float: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (gtri_src && !i_extest) |=> o_out_oe == '0)
        else $error("outputs driven under three-state");
    a_grst_user: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_q == gorc_pkg::ST_USER && grst_src && !pd) |=> o_global_set_reset)
        else $error("user reset not applied");
    // Release before configuration completed must go back to the timeout
    sequence s_pd_precfg;
        pd ##1 (!pd && !(cfg_started_q && i_cfg_done));
    endsequence
    a_pd_restart: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        s_pd_precfg |=> state_q == gorc_pkg::ST_POR)
        else $error("configuration not restarted");
    a_init_inval: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        pd |=> !o_init_valid)
        else $error("init status valid in power-down");
    a_osc_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_q == gorc_pkg::ST_USER && !i_osc_used) |=> !o_osc_out)
        else $error("oscillator not stopped");
    a_cfgclk_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_q != gorc_pkg::ST_CONFIG) [*2] |-> !o_configuration_clock)
        else $error("config clock outside configuration");
    // Internal source with its sense selected must show on the reset output
    a_grst_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_grst_use_node && i_grst_node != i_grst_invert) |=> o_global_set_reset)
        else $error("reset source select wrong");
endmodule : gorc_top

// File: sim/gorc_board_model.sv
// Board-side model that drives the power-down pin of the controller
module gorc_board_model (
    input wire logic i_clk,          // Oscillator clock
    input wire logic i_cfg_active,   // Device is configuring
    input wire logic i_pd_req,       // Power-down wanted by the board
    input wire logic i_break,        // Let power-down through while configuring
    output logic o_power_down_pin_n  // Pin into the device, low requests power-down
);
    timeunit 1ns;
    timeprecision 1ns;
    // Updated on the falling edge so the device never samples a moving pin
    initial o_power_down_pin_n = 1'b1;
    always @(negedge i_clk) begin
        o_power_down_pin_n <= !(i_pd_req && (!i_cfg_active || i_break));
    end
endmodule : gorc_board_model

// File: sim/gorc_top_test.sv
// Self-checking testbench of the global oscillator, reset and power-down controller
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
`define WAIT(c, n) begin for (int k = 0; k < n && !(c); k++) @(negedge i_clk); end
module gorc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b1;
    logic i_sys_rst = 1'b1;
    logic pd_n, pd_req, brk, i_reconfig, i_master_mode, i_cfg_done, i_osc_used, i_extest;
    logic [1:0] i_sel_a, i_sel_b;
    logic grst_pin, grst_node, grst_use, grst_inv, act, ta;
    logic gtri_pin, gtri_node, gtri_use, gtri_inv;
    logic [7:0] i_ff_set, i_ff_d, i_user_in, i_out_en;
    logic [7:0] o_ff_q, o_in_gated, o_out_oe;
    logic o_grst, o_osc_out, o_tap_a, o_tap_b, o_cfgclk, o_cfg_active, o_init_valid;
    logic o_user_mode, o_power_down;
    int miscompares = 0;
    int n_compared = 0;
    // Clock starts high so the first falling edge comes before the first sample
    always #50 i_clk = ~i_clk;
    gorc_board_model board (.i_clk(i_clk), .i_cfg_active(o_cfg_active), .i_pd_req(pd_req),
        .i_break(brk), .o_power_down_pin_n(pd_n));
    gorc_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_power_down_pin_n(pd_n),
        .i_reconfig(i_reconfig), .i_master_mode(i_master_mode), .i_cfg_done(i_cfg_done),
        .i_osc_used(i_osc_used), .i_sel_a(i_sel_a), .i_sel_b(i_sel_b), .i_grst_pin(grst_pin),
        .i_grst_node(grst_node), .i_grst_use_node(grst_use), .i_grst_invert(grst_inv),
        .i_gtri_pin(gtri_pin), .i_gtri_node(gtri_node), .i_gtri_use_node(gtri_use),
        .i_gtri_invert(gtri_inv), .i_extest(i_extest), .i_ff_set(i_ff_set), .i_ff_d(i_ff_d),
        .i_user_in(i_user_in), .i_out_en(i_out_en), .o_ff_q(o_ff_q), .o_in_gated(o_in_gated),
        .o_out_oe(o_out_oe), .o_global_set_reset(o_grst), .o_osc_out(o_osc_out),
        .o_tap_a(o_tap_a), .o_tap_b(o_tap_b), .o_configuration_clock(o_cfgclk),
        .o_cfg_active(o_cfg_active), .o_init_valid(o_init_valid), .o_user_mode(o_user_mode),
        .o_power_down(o_power_down));
    // Advance by whole cycles, landing on a falling edge
    task step(input int n);
        repeat (n) @(negedge i_clk);
    endtask : step
    // Prints the counts and the verdict, then stops the run
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // Watchdog sized well above the three configuration runs and the slow tap wait
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        end_sim();
    end
    initial begin
        {pd_req, brk, i_reconfig, i_cfg_done, i_extest, i_sel_a} = 6'h00;
        {grst_pin, grst_node, grst_use, grst_inv} = 4'h0;
        {gtri_pin, gtri_node, gtri_use, gtri_inv} = 4'h0;
        {i_master_mode, i_osc_used, i_sel_b} = 4'hd;
        {i_ff_set, i_ff_d, i_user_in, i_out_en} = 32'ha53cffff;
        // Three rising edges see reset high before it is released
        step(4);
        `CHK("grst at reset", 1'b1, o_grst)
        `CHK("ff at reset", 8'h00, o_ff_q)
        i_sys_rst = 1'b0;
        `WAIT(o_cfg_active, 200)
        `CHK("configuring", 1'b1, o_cfg_active)
        `WAIT(o_cfgclk, 20)
        `CHK("config clock", 1'b1, o_cfgclk)
        pd_req = 1'b1;
        step(3);
        `CHK("pd held off", 1'b0, o_power_down)
        {pd_req, i_cfg_done} = 2'h1;
        `WAIT(o_user_mode, 20)
        step(1);
        `CHK("user mode", 1'b1, o_user_mode)
        `CHK("grst off", 1'b0, o_grst)
        `CHK("ff runs", 8'h3c, o_ff_q)
        `CHK("init valid", 1'b1, o_init_valid)
        `CHK("osc kept", 1'b1, o_osc_out)
        // Every source, select and sense combination of both global nets
        for (int i = 0; i < 32; i++) begin
            {i_extest, grst_use, grst_pin, grst_node, grst_inv} = 5'(i);
            {gtri_use, gtri_pin, gtri_node, gtri_inv} = 4'(i);
            act = (grst_use ? grst_node : grst_pin) ^ grst_inv;
            step(2);
            `CHK("grst net", act, o_grst)
            `CHK("ff under grst", act ? 8'ha5 : 8'h3c, o_ff_q)
            `CHK("out enables", (act && !i_extest) ? 8'h00 : 8'hff, o_out_oe)
        end
        {i_extest, grst_use, grst_pin, grst_node, grst_inv} = 5'h00;
        {gtri_use, gtri_pin, gtri_node, gtri_inv} = 4'h0;
        i_osc_used = 1'b0;
        step(2);
        `CHK("osc stopped", 1'b0, o_osc_out)
        i_osc_used = 1'b1;
        ta = o_tap_a;
        `WAIT(o_tap_a !== ta, 40)
        `CHK("tap bit 4", !ta, o_tap_a)
        ta = o_tap_b;
        `WAIT(o_tap_b !== ta, 1100)
        `CHK("tap bit 9", !ta, o_tap_b)
        // Slow taps are still low this soon after the divider restarted
        {i_sel_a, i_sel_b} = 4'hb;
        step(2);
        `CHK("tap bit 14", 1'b0, o_tap_a)
        `CHK("tap bit 19", 1'b0, o_tap_b)
        pd_req = 1'b1;
        step(3);
        `CHK("pd state", 1'b1, o_power_down)
        `CHK("inputs low", 8'h00, o_in_gated)
        `CHK("ff lost", 8'ha5, o_ff_q)
        pd_req = 1'b0;
        step(4);
        `CHK("pd left", 1'b0, o_power_down)
        `CHK("back to user", 1'b1, o_user_mode)
        `CHK("inputs seen", 8'hff, o_in_gated)
        {i_cfg_done, i_reconfig} = 2'h1;
        step(1);
        i_reconfig = 1'b0;
        `WAIT(o_cfg_active, 200)
        {brk, pd_req} = 2'h3;
        step(3);
        `CHK("pd in config", 1'b1, o_power_down)
        `CHK("init invalid", 1'b0, o_init_valid)
        pd_req = 1'b0;
        step(4);
        `CHK("restarted", 1'b0, o_cfg_active)
        `WAIT(o_cfg_active, 200)
        `CHK("config again", 1'b1, o_cfg_active)
        end_sim();
    end
endmodule : gorc_top_test
